// >>> rtl/cdau_core.sv
// operand address generation, program targets and data space access
`default_nettype none
// Behaviour
// - displacement mode adds six unsigned instruction bits to any of the three pointers
// - plain indirect uses any pointer unchanged as the operand address
// - pre-decrement lowers the pointer first, uses and keeps the new value
// - post-increment uses the old value, bumps the pointer after the access
// - program constant load: pointer bits 15..1 pick word, bit 0 picks byte
// - jump and call via pointer load the program counter from third pointer
// - relative jump and call go to counter plus offset plus one
// - the core runs straight on the clock, no division
// - fetch of the next instruction overlaps execution of the current one
// - register to register operation reads, computes, writes back in one cycle
// - every internal sram access takes two clock cycles
// - i/o read and write reach i/o addresses 00 to 3f
// - i/o registers in the data space sit 20 above their i/o address
// - bit set, clear and skip tests only work on i/o addresses 00 to 1f
// - certain status flags clear when written with a one
// - bit set and clear rewrite the whole register, clearing flags read as set
// - working registers occupy data addresses 0000 to 001f
// - first 96 addresses are registers plus i/o, next 1024 are sram
module cdau_core #(
    parameter int SRAM_DEPTH = cdau_pkg::SRAM_WORDS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire cdau_pkg::cdau_cmd_s cmd,
    input wire logic [15:0] fetch_word,
    input wire logic [7:0] periph_rdata,
    input wire logic [63:0] periph_present,
    output logic cmd_ready,
    output logic [12:0] pc,
    output logic [12:0] fetch_addr,
    output logic [15:0] instr_reg,
    output logic [14:0] pm_word_addr,
    output logic pm_high_byte,
    output logic [7:0] load_data,
    output logic load_valid,
    output logic skip_next,
    output logic [15:0] operand_addr,
    output var cdau_pkg::cdau_io_s periph_bus,
    output logic [15:0] stack_pointer,
    output logic [7:0] status_flags
);
    typedef enum {ST_IDLE, ST_SRAM} cdau_state_e;

    logic [7:0] regs [0:31];
    logic [7:0] sram [0:SRAM_DEPTH-1];
    cdau_state_e state;
    cdau_pkg::cdau_cmd_s held;
    logic [15:0] held_addr;
    logic [15:0] ptr;
    logic [15:0] eff_addr;
    logic [15:0] next_ptr;
    logic io_rd;
    logic io_wr;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic periph_wr;
    logic [7:0] bit_mask;
    logic accept;
    logic [7:0] sum;

    // pointer pairs live in the top six working registers
    function automatic logic [15:0] ptr_of(input logic [1:0] sel, input logic [7:0] lo,
            input logic [7:0] hi);
        ptr_of = {hi, lo};
    endfunction : ptr_of

    function automatic logic [4:0] ptr_lo_idx(input logic [1:0] sel);
        unique case (sel)
            2'd0: ptr_lo_idx = 5'd26;
            2'd1: ptr_lo_idx = 5'd28;
            default: ptr_lo_idx = 5'd30;
        endcase
    endfunction : ptr_lo_idx

    // which region a data address hits
    function automatic logic is_io(input logic [15:0] a);
        is_io = a >= cdau_pkg::IO_DATA_OFFSET && a < cdau_pkg::SRAM_BASE;
    endfunction : is_io

    function automatic logic is_sram(input logic [15:0] a);
        is_sram = a >= cdau_pkg::SRAM_BASE && a <= cdau_pkg::SRAM_END;
    endfunction : is_sram

    assign ptr = ptr_of(cmd.ptr_sel, regs[ptr_lo_idx(cmd.ptr_sel)],
        regs[ptr_lo_idx(cmd.ptr_sel) + 5'd1]);
    assign accept = cmd_valid && cmd_ready;
    assign bit_mask = 8'h01 << cmd.bit_sel;
    assign sum = regs[cmd.rd] + regs[cmd.rr];

    // effective address and pointer update per mode
    always_comb begin
        eff_addr = ptr;
        next_ptr = ptr;
        unique case (cmd.mode)
            cdau_pkg::CDAU_AM_DISP: eff_addr = ptr + {10'h000, cmd.disp};
            cdau_pkg::CDAU_AM_PREDEC: begin
                eff_addr = ptr - 16'h0001;
                next_ptr = ptr - 16'h0001;
            end
            cdau_pkg::CDAU_AM_POSTINC: next_ptr = ptr + 16'h0001;
            default: ;
        endcase
    end

    // i/o side: direct i/o ops, or data accesses landing in the window
    always_comb begin
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_addr = cmd.io_addr;
        io_wdata = regs[cmd.rd];
        // peripherals must answer io_addr within this same cycle
        if (accept) begin
            unique case (cmd.op)
                cdau_pkg::CDAU_OP_IO_READ: io_rd = 1'b1;
                cdau_pkg::CDAU_OP_IO_WRITE: io_wr = 1'b1;
                cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_SET, cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_CLEAR:
                    io_rd = cmd.io_addr <= cdau_pkg::IO_BIT_LAST;
                cdau_pkg::CDAU_OP_IO_BIT_SET, cdau_pkg::CDAU_OP_IO_BIT_CLEAR: begin
                    // whole byte written back: flags read as one get cleared
                    io_rd = cmd.io_addr <= cdau_pkg::IO_BIT_LAST;
                    io_wr = io_rd;
                    io_wdata = (cmd.op == cdau_pkg::CDAU_OP_IO_BIT_SET) ?
                        (io_rdata | bit_mask) : (io_rdata & ~bit_mask);
                end
                cdau_pkg::CDAU_OP_LOAD, cdau_pkg::CDAU_OP_STORE: begin
                    io_addr = 6'(eff_addr - cdau_pkg::IO_DATA_OFFSET);
                    io_rd = is_io(eff_addr) && cmd.op == cdau_pkg::CDAU_OP_LOAD;
                    io_wr = is_io(eff_addr) && cmd.op == cdau_pkg::CDAU_OP_STORE;
                end
                default: ;
            endcase
        end
    end

    cdau_io_space u_io (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rd_en(io_rd),
        .wr_en(io_wr),
        .addr(io_addr),
        .wdata(io_wdata),
        .periph_rdata(periph_rdata),
        .periph_present(periph_present),
        .rdata(io_rdata),
        .periph_wr(periph_wr),
        .stack_pointer(stack_pointer),
        .status_flags(status_flags)
    );

    // two-cycle sram sequencing; stalls the decoder in between
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cmd_ready <= 1'b1;
            held <= '0;
            held_addr <= 16'h0000;
        end else if (state == ST_IDLE) begin
            if (accept && is_sram(eff_addr) && (cmd.op == cdau_pkg::CDAU_OP_LOAD ||
                    cmd.op == cdau_pkg::CDAU_OP_STORE)) begin
                state <= ST_SRAM;
                cmd_ready <= 1'b0;
                held <= cmd;
                held_addr <= eff_addr;
            end
        end else begin
            state <= ST_IDLE;
            cmd_ready <= 1'b1;
        end
    end

    // working registers: alu, loads, pointer updates
    always_ff @(posedge core_clk) begin
        if (accept) begin
            if (cmd.op == cdau_pkg::CDAU_OP_ALU_ADD)
                regs[cmd.rd] <= sum;
            else if (cmd.op == cdau_pkg::CDAU_OP_IO_READ)
                regs[cmd.rd] <= io_rdata;
            else if ((cmd.op == cdau_pkg::CDAU_OP_LOAD || cmd.op == cdau_pkg::CDAU_OP_STORE)
                    && cmd.mode != cdau_pkg::CDAU_AM_DISP) begin
                regs[ptr_lo_idx(cmd.ptr_sel)] <= next_ptr[7:0];
                regs[ptr_lo_idx(cmd.ptr_sel) + 5'd1] <= next_ptr[15:8];
            end
            // low register space reached through a pointer
            if (cmd.op == cdau_pkg::CDAU_OP_STORE && eff_addr < cdau_pkg::IO_DATA_OFFSET)
                regs[eff_addr[4:0]] <= regs[cmd.rd];
            else if (cmd.op == cdau_pkg::CDAU_OP_LOAD && eff_addr < cdau_pkg::IO_DATA_OFFSET)
                regs[cmd.rd] <= regs[eff_addr[4:0]];
            else if (cmd.op == cdau_pkg::CDAU_OP_LOAD && is_io(eff_addr))
                regs[cmd.rd] <= io_rdata;
        end else if (state == ST_SRAM && held.op == cdau_pkg::CDAU_OP_LOAD) begin
            regs[held.rd] <= sram[10'(held_addr - cdau_pkg::SRAM_BASE)];
        end
        // store lands in the stalled second cycle
        if (state == ST_SRAM && held.op == cdau_pkg::CDAU_OP_STORE)
            sram[10'(held_addr - cdau_pkg::SRAM_BASE)] <= regs[held.rd];
    end

    // program counter and overlapped fetch, no clock division anywhere
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc <= 13'h0000;
            fetch_addr <= 13'h0000;
            instr_reg <= 16'h0000;
        end else if (accept) begin
            instr_reg <= fetch_word;
            unique case (cmd.op)
                cdau_pkg::CDAU_OP_JUMP_VIA_POINTER, cdau_pkg::CDAU_OP_CALL_VIA_POINTER: begin
                    // upper pointer bits fall off the counter
                    pc <= {regs[31][4:0], regs[30]};
                    fetch_addr <= {regs[31][4:0], regs[30]};
                end
                cdau_pkg::CDAU_OP_RELATIVE_JUMP, cdau_pkg::CDAU_OP_RELATIVE_CALL: begin
                    pc <= pc + 13'(signed'(cmd.rel_k)) + 13'h0001;
                    fetch_addr <= pc + 13'(signed'(cmd.rel_k)) + 13'h0002;
                end
                default: begin
                    pc <= pc + 13'h0001;
                    fetch_addr <= pc + 13'h0002;
                end
            endcase
        end
    end

    // outward results, all registered
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pm_word_addr <= 15'h0000;
            pm_high_byte <= 1'b0;
            load_data <= 8'h00;
            load_valid <= 1'b0;
            skip_next <= 1'b0;
            operand_addr <= 16'h0000;
            periph_bus <= '0;
        end else begin
            load_valid <= 1'b0;
            skip_next <= 1'b0;
            // late copy for observers; reads use io_rdata
            periph_bus <= '{rd_en: io_rd, wr_en: periph_wr, addr: io_addr, wdata: io_wdata};
            if (accept) begin
                operand_addr <= eff_addr;
                if (cmd.op == cdau_pkg::CDAU_OP_PROGRAM_MEMORY_LOAD) begin
                    pm_word_addr <= {regs[31], regs[30][7:1]};
                    pm_high_byte <= regs[30][0];
                end
                if (io_rd && cmd.op == cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_SET)
                    skip_next <= (io_rdata & bit_mask) != 8'h00;
                if (io_rd && cmd.op == cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_CLEAR)
                    skip_next <= (io_rdata & bit_mask) == 8'h00;
                if (cmd.op == cdau_pkg::CDAU_OP_IO_READ) begin
                    load_data <= io_rdata;
                    load_valid <= 1'b1;
                end
            end else if (state == ST_SRAM && held.op == cdau_pkg::CDAU_OP_LOAD) begin
                load_data <= sram[10'(held_addr - cdau_pkg::SRAM_BASE)];
                load_valid <= 1'b1;
            end
        end
    end

    // checks look at registered results, except the bit range and i/o offset checks, which look at the decode itself
    AST_SRAM_TWO: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == ST_SRAM |=> cmd_ready && state == ST_IDLE)
        else $error("sram access not two cycles");
    AST_SRAM_STALL: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && is_sram(eff_addr) && cmd.op == cdau_pkg::CDAU_OP_LOAD |=> !cmd_ready)
        else $error("sram load did not stall");
    AST_PREDEC: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.mode == cdau_pkg::CDAU_AM_PREDEC |=> operand_addr == $past(ptr) - 16'h0001)
        else $error("predecrement address wrong");
    AST_POSTINC: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.mode == cdau_pkg::CDAU_AM_POSTINC |=> operand_addr == $past(ptr))
        else $error("postincrement address wrong");
    AST_DISP: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.mode == cdau_pkg::CDAU_AM_DISP
        |=> operand_addr == $past(ptr + {10'h000, cmd.disp}))
        else $error("displacement address wrong");
    AST_REL: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.op == cdau_pkg::CDAU_OP_RELATIVE_JUMP
        |=> pc == $past(pc) + 13'($past(signed'(cmd.rel_k))) + 13'h0001)
        else $error("relative target wrong");
    AST_BIT_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.op == cdau_pkg::CDAU_OP_IO_BIT_SET && cmd.io_addr > 6'h1f |-> !io_wr)
        else $error("bit op above 1f");
    AST_IO_OFFSET: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.op == cdau_pkg::CDAU_OP_LOAD && is_io(eff_addr)
        |-> io_rd && {10'h000, io_addr} == eff_addr - 16'h0020)
        else $error("io data offset wrong");
    AST_PM_BYTE: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd.op == cdau_pkg::CDAU_OP_PROGRAM_MEMORY_LOAD
        |=> pm_high_byte == $past(regs[30][0]))
        else $error("program byte select wrong");
endmodule : cdau_core
`default_nettype wire

// >>> rtl/cdau_io_space.sv
// i/o space decoder with the core registers and peripheral pass-through
`default_nettype none
module cdau_io_space (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] periph_rdata,
    input wire logic [63:0] periph_present,
    output logic [7:0] rdata,
    output logic periph_wr,
    output logic [15:0] stack_pointer,
    output logic [7:0] status_flags
);
    logic [7:0] stack_pointer_low;
    logic [7:0] stack_pointer_high;

    // core registers; writes to absent locations are dropped
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stack_pointer_low <= cdau_pkg::STACK_POINTER_LOW_RESET;
            stack_pointer_high <= cdau_pkg::STACK_POINTER_HIGH_RESET;
            status_flags <= cdau_pkg::STATUS_FLAGS_RESET;
        end else if (wr_en) begin
            unique case (addr)
                cdau_pkg::STACK_POINTER_LOW_ADDR: stack_pointer_low <= wdata;
                cdau_pkg::STACK_POINTER_HIGH_ADDR:
                    stack_pointer_high <= wdata & cdau_pkg::STACK_POINTER_HIGH_MASK;
                cdau_pkg::STATUS_FLAGS_ADDR: status_flags <= wdata;
                default: ;
            endcase
        end
    end

    assign stack_pointer = {stack_pointer_high, stack_pointer_low};
    // peripherals only see writes to locations that exist
    assign periph_wr = wr_en && periph_present[addr] && (addr < cdau_pkg::STACK_POINTER_LOW_ADDR);

    // read mux; absent locations read as zero
    always_comb begin
        rdata = 8'h00;
        if (rd_en) begin
            unique case (addr)
                cdau_pkg::STACK_POINTER_LOW_ADDR: rdata = stack_pointer_low;
                cdau_pkg::STACK_POINTER_HIGH_ADDR: rdata = stack_pointer_high;
                cdau_pkg::STATUS_FLAGS_ADDR: rdata = status_flags;
                default: rdata = periph_present[addr] ? periph_rdata : 8'h00;
            endcase
        end
    end
endmodule : cdau_io_space
`default_nettype wire

// >>> rtl/cdau_pkg.sv
// package for the cpu data address unit: map, modes, commands, timing
`default_nettype none
package cdau_pkg;
    // data space decode
    localparam logic [15:0] REGFILE_BASE = 16'h0000;
    localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] SRAM_END = 16'h045f;
    localparam int SRAM_WORDS = 1024;
    localparam logic [5:0] IO_LAST = 6'h3f;
    localparam logic [5:0] IO_BIT_LAST = 6'h1f;
    // core registers in i/o space
    localparam logic [5:0] STACK_POINTER_LOW_ADDR = 6'h3d;
    localparam logic [5:0] STACK_POINTER_HIGH_ADDR = 6'h3e;
    localparam logic [5:0] STATUS_FLAGS_ADDR = 6'h3f;
    localparam logic [7:0] STACK_POINTER_LOW_RESET = 8'h00;
    localparam logic [7:0] STACK_POINTER_HIGH_RESET = 8'h00;
    localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
    localparam logic [7:0] STACK_POINTER_HIGH_MASK = 8'h07;
    // timing in core cycles
    localparam int SRAM_ACCESS_CYCLES = 2;
    localparam int PC_WIDTH = 13;

    typedef enum logic [2:0] {
        CDAU_AM_PLAIN,
        CDAU_AM_DISP,
        CDAU_AM_PREDEC,
        CDAU_AM_POSTINC,
        CDAU_AM_NONE
    } cdau_mode_e;

    typedef enum logic [3:0] {
        CDAU_OP_NOP,
        CDAU_OP_LOAD,
        CDAU_OP_STORE,
        CDAU_OP_IO_READ,
        CDAU_OP_IO_WRITE,
        CDAU_OP_IO_BIT_SET,
        CDAU_OP_IO_BIT_CLEAR,
        CDAU_OP_SKIP_IF_IO_BIT_SET,
        CDAU_OP_SKIP_IF_IO_BIT_CLEAR,
        CDAU_OP_PROGRAM_MEMORY_LOAD,
        CDAU_OP_JUMP_VIA_POINTER,
        CDAU_OP_CALL_VIA_POINTER,
        CDAU_OP_RELATIVE_JUMP,
        CDAU_OP_RELATIVE_CALL,
        CDAU_OP_ALU_ADD
    } cdau_op_e;

    // one decoded instruction from the decoder
    typedef struct packed {
        cdau_op_e op;
        cdau_mode_e mode;
        logic [1:0] ptr_sel;
        logic [5:0] disp;
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [11:0] rel_k;
    } cdau_cmd_s;

    // one access towards peripheral registers
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cdau_io_s;
endpackage : cdau_pkg
`default_nettype wire

// >>> tb/cdau_periph_model.sv
// partner model: peripheral register blocks behind the core's i/o space
`default_nettype none
module cdau_periph_model #(
    parameter logic [5:0] W1C_ADDR = 6'h0e,
    parameter logic [7:0] W1C_MASK = 8'h80
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire cdau_pkg::cdau_io_s periph_bus,
    input wire logic [5:0] rd_addr,
    output logic [7:0] periph_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] io_regs [64];
    initial begin
        foreach (io_regs[i]) io_regs[i] = 8'h00;
    end
    // read is combinational since the core samples it in the accept cycle
    assign periph_rdata = io_regs[rd_addr];
    // flag bits clear only where a one is written; hardware alone sets them
    always @(posedge core_clk) begin
        if (!sys_rst && periph_bus.wr_en) begin
            if (periph_bus.addr == W1C_ADDR) begin
                io_regs[periph_bus.addr] <= (periph_bus.wdata & ~W1C_MASK) |
                    (io_regs[periph_bus.addr] & W1C_MASK & ~periph_bus.wdata);
            end else begin
                io_regs[periph_bus.addr] <= periph_bus.wdata;
            end
        end
    end
endmodule : cdau_periph_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the cpu data address unit core
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    cdau_pkg::cdau_cmd_s cmd = '0;
    logic [63:0] periph_present = 64'h1fff_fff7_ffff_ffff; // location 23 absent
    logic [7:0] periph_rdata, load_data, status_flags;
    logic cmd_ready, pm_high_byte, load_valid, skip_next;
    logic [12:0] pc, pc_at_take, fetch_addr;
    logic [14:0] pm_word_addr;
    logic [15:0] operand_addr, stack_pointer;
    cdau_pkg::cdau_io_s periph_bus;
    int err_total = 0;
    int checked = 0;
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    cdau_core i_cdau_core (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .fetch_word(16'h0000), .periph_rdata(periph_rdata),
        .periph_present(periph_present), .cmd_ready(cmd_ready), .pc(pc), .fetch_addr(fetch_addr),
        .instr_reg(), .pm_word_addr(pm_word_addr), .pm_high_byte(pm_high_byte),
        .load_data(load_data), .load_valid(load_valid), .skip_next(skip_next),
        .operand_addr(operand_addr), .periph_bus(periph_bus),
        .stack_pointer(stack_pointer), .status_flags(status_flags));
    cdau_periph_model i_cdau_periph_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .periph_bus(periph_bus), .rd_addr(cmd.io_addr), .periph_rdata(periph_rdata));
    // offer one command, hold it until taken, release half a cycle later
    task automatic take(input cdau_pkg::cdau_cmd_s c);
        int n;
        n = 0;
        @(negedge core_clk);
        cmd = c;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n < 20, 1'b1)
        pc_at_take = pc;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask : take
    // x feeds displacement, bit select and offset; rd and rr share r
    task automatic go(input cdau_pkg::cdau_op_e op, input cdau_pkg::cdau_mode_e md,
            input logic [1:0] ps, input logic [5:0] ia, input logic [4:0] r,
            input logic [11:0] x);
        cdau_pkg::cdau_cmd_s c;
        c = '0;
        c.op = op;
        c.mode = md;
        c.ptr_sel = ps;
        c.io_addr = ia;
        c.rd = r;
        c.rr = r;
        c.disp = x[5:0];
        c.bit_sel = x[2:0];
        c.rel_k = x;
        take(c);
    endtask : go
    // working registers reach values only through an i/o read of scratch 12
    task automatic setr(input logic [4:0] r, input logic [7:0] v);
        i_cdau_periph_model.io_regs[6'h12] = v;
        go(cdau_pkg::CDAU_OP_IO_READ, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h12, r, 12'h000);
    endtask : setr
    task automatic setp(input logic [1:0] ps, input logic [15:0] v);
        setr(5'd26 + {2'b00, ps, 1'b0}, v[7:0]);
        setr(5'd27 + {2'b00, ps, 1'b0}, v[15:8]);
    endtask : setp
    // a register is observed by writing it out to peripheral location 13
    task automatic chk(input logic [4:0] r, input logic [7:0] v);
        go(cdau_pkg::CDAU_OP_IO_WRITE, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h13, r, 12'h000);
        repeat (2) @(negedge core_clk);
        `CHK(i_cdau_periph_model.io_regs[6'h13], v)
    endtask : chk
    task automatic lwait(input logic [7:0] v);
        `CHK({cmd_ready, load_valid}, 2'b00)
        @(negedge core_clk);
        `CHK(load_valid, 1'b1)
        `CHK(load_data, v)
    endtask : lwait
    task automatic ld(input cdau_pkg::cdau_mode_e md, input logic [1:0] ps,
            input logic [11:0] x, input logic [15:0] a);
        go(cdau_pkg::CDAU_OP_LOAD, md, ps, 6'h00, 5'd9, x);
        `CHK(operand_addr, a)
    endtask : ld
    task automatic t_reset();
        `CHK(stack_pointer, {cdau_pkg::STACK_POINTER_HIGH_RESET,
            cdau_pkg::STACK_POINTER_LOW_RESET})
        `CHK(status_flags, cdau_pkg::STATUS_FLAGS_RESET)
        `CHK(cmd_ready, 1'b1)
        $display("test reset done");
    endtask : t_reset
    task automatic t_io();
        setr(5'd1, 8'hff);
        setr(5'd2, 8'h05); // reserved high bits of the pointer written as zero
        go(cdau_pkg::CDAU_OP_IO_WRITE, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h3d, 5'd1, 12'h0);
        go(cdau_pkg::CDAU_OP_IO_WRITE, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h3e, 5'd2, 12'h0);
        go(cdau_pkg::CDAU_OP_IO_WRITE, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h3f, 5'd1, 12'h0);
        `CHK(stack_pointer, 16'h05ff)
        `CHK(status_flags, 8'hff)
        go(cdau_pkg::CDAU_OP_IO_READ, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h3e, 5'd4, 12'h0);
        chk(5'd4, 8'h05);
        i_cdau_periph_model.io_regs[6'h23] = 8'h5a;
        // absent location is only read, never written
        go(cdau_pkg::CDAU_OP_IO_READ, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h23, 5'd5, 12'h0);
        repeat (2) @(negedge core_clk);
        `CHK(i_cdau_periph_model.io_regs[6'h23], 8'h5a)
        chk(5'd5, 8'h00);
        setr(5'd2, 8'h30);
        setr(5'd3, 8'h25);
        go(cdau_pkg::CDAU_OP_ALU_ADD, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h00, 5'd2, 12'h0);
        chk(5'd2, 8'h60); // same register on both sides doubles it
        $display("test io done");
    endtask : t_io
    task automatic t_modes();
        setr(5'd1, 8'hc3);
        setp(2'd0, 16'h0060);
        go(cdau_pkg::CDAU_OP_STORE, cdau_pkg::CDAU_AM_POSTINC, 2'd0, 6'h0, 5'd1, 12'h0);
        `CHK(operand_addr, 16'h0060)
        ld(cdau_pkg::CDAU_AM_PLAIN, 2'd0, 12'h000, 16'h0061);
        ld(cdau_pkg::CDAU_AM_PREDEC, 2'd0, 12'h000, 16'h0060);
        lwait(8'hc3);
        chk(5'd26, 8'h60);
        setp(2'd1, 16'h0040);
        ld(cdau_pkg::CDAU_AM_DISP, 2'd1, 12'h020, 16'h0060);
        lwait(8'hc3);
        setp(2'd2, 16'h0021);
        ld(cdau_pkg::CDAU_AM_DISP, 2'd2, 12'h03f, 16'h0060);
        setp(2'd2, 16'h0001);
        go(cdau_pkg::CDAU_OP_LOAD, cdau_pkg::CDAU_AM_PLAIN, 2'd2, 6'h0, 5'd8, 12'h0);
        chk(5'd8, 8'hc3);
        setp(2'd0, 16'h0031);
        go(cdau_pkg::CDAU_OP_STORE, cdau_pkg::CDAU_AM_PLAIN, 2'd0, 6'h0, 5'd1, 12'h0);
        repeat (2) @(negedge core_clk);
        `CHK(i_cdau_periph_model.io_regs[6'h11], 8'hc3)
        go(cdau_pkg::CDAU_OP_LOAD, cdau_pkg::CDAU_AM_PLAIN, 2'd0, 6'h11, 5'd10, 12'h0);
        chk(5'd10, 8'hc3);
        setp(2'd0, 16'h0000);
        ld(cdau_pkg::CDAU_AM_PREDEC, 2'd0, 12'h000, 16'hffff);
        chk(5'd27, 8'hff);
        setp(2'd0, 16'hffff);
        ld(cdau_pkg::CDAU_AM_POSTINC, 2'd0, 12'h000, 16'hffff);
        chk(5'd27, 8'h00);
        $display("test modes done");
    endtask : t_modes
    task automatic rel(input cdau_pkg::cdau_op_e op, input logic [11:0] k);
        go(op, cdau_pkg::CDAU_AM_NONE, 2'd0, 6'h0, 5'd0, k);
        `CHK(pc, pc_at_take + {k[11], k} + 13'd1)
        `CHK(fetch_addr, pc + 13'd1)
    endtask : rel
    task automatic t_prog();
        // only constant loads are issued, so bit 0 may be set here
        setp(2'd2, 16'h1235);
        go(cdau_pkg::CDAU_OP_PROGRAM_MEMORY_LOAD, cdau_pkg::CDAU_AM_NONE, 2'd2, 6'h0, 5'd9,
            12'h0);
        `CHK({pm_word_addr, pm_high_byte}, {15'h091a, 1'b1})
        setr(5'd30, 8'h34);
        go(cdau_pkg::CDAU_OP_PROGRAM_MEMORY_LOAD, cdau_pkg::CDAU_AM_NONE, 2'd2, 6'h0, 5'd9,
            12'h0);
        `CHK({pm_word_addr, pm_high_byte}, {15'h091a, 1'b0})
        setp(2'd2, 16'h0abc);
        go(cdau_pkg::CDAU_OP_JUMP_VIA_POINTER, cdau_pkg::CDAU_AM_NONE, 2'd2, 6'h0, 5'd0, 12'h0);
        `CHK(pc, 13'h0abc)
        setp(2'd2, 16'h1555);
        go(cdau_pkg::CDAU_OP_CALL_VIA_POINTER, cdau_pkg::CDAU_AM_NONE, 2'd2, 6'h0, 5'd0, 12'h0);
        `CHK(pc, 13'h1555)
        rel(cdau_pkg::CDAU_OP_RELATIVE_JUMP, 12'h7ff);
        rel(cdau_pkg::CDAU_OP_RELATIVE_CALL, 12'h800);
        rel(cdau_pkg::CDAU_OP_RELATIVE_JUMP, 12'hfff);
        $display("test program done");
    endtask : t_prog
    task automatic bop(input cdau_pkg::cdau_op_e op, input logic [5:0] a,
            input logic [2:0] b, input logic [7:0] v);
        go(op, cdau_pkg::CDAU_AM_NONE, 2'd0, a, 5'd0, {9'h000, b});
        repeat (2) @(negedge core_clk);
        `CHK(i_cdau_periph_model.io_regs[a], v)
    endtask : bop
    task automatic skp(input cdau_pkg::cdau_op_e op, input logic [5:0] a,
            input logic [2:0] b, input logic s);
        go(op, cdau_pkg::CDAU_AM_NONE, 2'd0, a, 5'd0, {9'h000, b});
        `CHK(skip_next, s)
    endtask : skp
    task automatic t_bits();
        i_cdau_periph_model.io_regs[6'h0e] = 8'h80;
        i_cdau_periph_model.io_regs[6'h05] = 8'hff;
        bop(cdau_pkg::CDAU_OP_IO_BIT_SET, 6'h0e, 3'd0, 8'h01);
        bop(cdau_pkg::CDAU_OP_IO_BIT_CLEAR, 6'h05, 3'd3, 8'hf7);
        bop(cdau_pkg::CDAU_OP_IO_BIT_SET, 6'h20, 3'd0, 8'h00);
        skp(cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_SET, 6'h05, 3'd0, 1'b1);
        skp(cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_SET, 6'h05, 3'd3, 1'b0);
        skp(cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_CLEAR, 6'h05, 3'd3, 1'b1);
        skp(cdau_pkg::CDAU_OP_SKIP_IF_IO_BIT_CLEAR, 6'h20, 3'd0, 1'b0);
        $display("test bits done");
    endtask : t_bits
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // main sequence: reset held twelve cycles, released off the sampling edge
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_io();
        t_modes();
        t_prog();
        t_bits();
        finish_test();
    end
    // watchdog: the tests need well under two thousand cycles
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
